// ==== lpfm_pkg.sv ====
// Package: constants and carrier structs for the protection and fault manager
package lpfm_pkg;

   // Clock rate
   localparam int unsigned CLK_MHZ = 200;

   // Times in their own units, as printed
   localparam int unsigned BLANK_NS = 400;
   localparam int unsigned CAP_DT_US = 150;
   localparam int unsigned FAST_OC_MS = 2;
   localparam int unsigned SLOW_OC_MS = 50;
   localparam int unsigned FAULT_WAIT_MS = 1000;

   // Derived cycle counts: least times round up, longest times round down
   localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CAP_DT_CYC = CAP_DT_US * CLK_MHZ;
   localparam int unsigned FAST_OC_CYC = FAST_OC_MS * 1000 * CLK_MHZ;
   localparam int unsigned SLOW_OC_CYC = SLOW_OC_MS * 1000 * CLK_MHZ;
   localparam int unsigned FAULT_WAIT_CYC = FAULT_WAIT_MS * 1000 * CLK_MHZ;

   // Consecutive-cycle counts
   localparam int unsigned PEAK_OC_CYCLES = 4;
   localparam int unsigned OVP_CYCLES = 5;
   localparam int unsigned PEAK_IGNORE_CYCLES = 15;

   // Counter widths
   localparam int unsigned TMR_W = 32;
   localparam int unsigned CNT_W = 5;

   // Comparator inputs from the analog front end
   typedef struct packed {
      logic current_direction_flag;
      logic slew_done;
      logic peak_overcurrent_fault;
      logic fast_average_overcurrent_fault;
      logic slow_average_overcurrent_fault;
      logic output_overvoltage_fault;
      logic input_undervoltage_fault;
      logic input_overvoltage_fault;
      logic bootstrap_uvlo;
      logic rail_uvlo;
      logic over_temp;
      logic supply_short_level;
      logic supply_start_level;
      logic light_load;
   } lpfm_sense_s;

   // Start-up supply controls
   typedef struct packed {
      logic hv_source_on;
      logic hv_source_high;
      logic rail_enable;
   } lpfm_supply_s;

   typedef enum logic [1:0] {
      ST_HV_START,
      ST_RUN,
      ST_FAULT_WAIT
   } lpfm_state_e;

   typedef enum logic [1:0] {
      PH_UPPER,
      PH_DEAD_TO_LOWER,
      PH_LOWER,
      PH_DEAD_TO_UPPER
   } lpfm_phase_e;

endpackage

// ==== lpfm_sync.sv ====
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module lpfm_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // lpfm_sync

// ==== lpfm_persist.sv ====
// Counts how long a level persists and flags when a limit is reached
`timescale 1ns/1ps
module lpfm_persist #(
   parameter int unsigned W = 32,
   parameter int unsigned LIMIT = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic clear,
   input wire logic step,
   input wire logic level,
   // Result
   output logic hit
);

   logic [W-1:0] cnt_q;

   // A low level on a step restarts the run; consecutive means unbroken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         hit <= 1'b0;
      end else if (clear) begin
         cnt_q <= '0;
         hit <= 1'b0;
      end else if (step) begin
         if (!level) begin
            cnt_q <= '0;
         end else if (cnt_q < W'(LIMIT)) begin
            cnt_q <= cnt_q + W'(1);
         end
         hit <= level && (cnt_q + W'(1) >= W'(LIMIT));
      end
   end

endmodule // lpfm_persist

// ==== lpfm_fault_manager.sv ====
// Protection, dead-time decision and fault sequencing for a half-bridge resonant stage
`timescale 1ns/1ps
// Function
// - Sample polarity at gate falls, detect capacitive
// - Flag holds until next gate fall
// - Capacitive: turn on at polarity flip
// - Capacitive: slew done also turns on
// - Else max dead time, 150 us capacitive
// - Capacitive: pull soft start low, recover
// - No capacitive detection at light load
// - Peak overcurrent 4 cycles: fault, 1 s
// - Fast average overcurrent 2 ms: fault
// - Slow average overcurrent 50 ms: fault
// - Bias overvoltage 5 cycles: fault, 1 s
// - Bulk undervoltage: immediate fault, restart 1 s
// - Bulk overvoltage: fault, restart once below
// - Bootstrap undervoltage: upper gate off only
// - Rail undervoltage: both off, fault, 1 s
// - Over temperature: fault, restart once cleared
// - Start-up source low, then high current
// - Supply start level: source off, rail on
// - Ignore peak comparator first 15 cycles
// - Blank polarity edges first 400 ns
module lpfm_fault_manager #(
   parameter int unsigned FAULT_WAIT = lpfm_pkg::FAULT_WAIT_CYC,
   parameter int unsigned FAST_OC = lpfm_pkg::FAST_OC_CYC,
   parameter int unsigned SLOW_OC = lpfm_pkg::SLOW_OC_CYC,
   parameter int unsigned CAP_DT = lpfm_pkg::CAP_DT_CYC,
   parameter int unsigned MAX_DT = 200,
   parameter int unsigned HALF_PERIOD = 1000,
   parameter bit HAS_INPUT_OVP = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Analog comparator pins
   input wire lpfm_pkg::lpfm_sense_s sense,
   // Gate on-signals
   output logic upper_gate_on,
   output logic lower_gate_on,
   // Soft start pull-down, open drain
   output logic soft_start_pin_o,
   output logic soft_start_pin_oe,
   // Supply control
   output lpfm_pkg::lpfm_supply_s supply,
   // Status
   output logic capacitive_region_flag,
   output logic fault_active
);

   lpfm_pkg::lpfm_sense_s s;
   lpfm_pkg::lpfm_state_e state_q;
   lpfm_pkg::lpfm_phase_e phase_q;
   logic [lpfm_pkg::TMR_W-1:0] ph_tmr_q;
   logic [lpfm_pkg::TMR_W-1:0] wait_q;
   logic [lpfm_pkg::TMR_W-1:0] fast_q;
   logic [lpfm_pkg::TMR_W-1:0] slow_q;
   logic [lpfm_pkg::CNT_W-1:0] start_cyc_q;
   logic dir_q;
   logic cap_q;
   logic running;
   logic gate_fall;
   logic cycle_end;
   logic in_dead;
   logic dir_flip;
   logic dead_done;
   logic peak_hit;
   logic ovp_hit;
   logic fast_hit;
   logic slow_hit;
   logic trip;
   logic hold;
   logic in_start;
   logic in_wait;
   logic blank_done;
   logic level_trip;
   logic count_trip;

   lpfm_sync #(.W($bits(lpfm_pkg::lpfm_sense_s))) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(sense),
      .q(s)
   );

   function automatic logic at_least(input logic [lpfm_pkg::TMR_W-1:0] c, input int unsigned n);
      at_least = (c + lpfm_pkg::TMR_W'(1)) >= lpfm_pkg::TMR_W'(n);
   endfunction

   assign running = (state_q == lpfm_pkg::ST_RUN);
   assign in_dead = (phase_q == lpfm_pkg::PH_DEAD_TO_LOWER) ||
                    (phase_q == lpfm_pkg::PH_DEAD_TO_UPPER);
   assign gate_fall = running && !in_dead && at_least(ph_tmr_q, HALF_PERIOD);
   assign cycle_end = gate_fall && (phase_q == lpfm_pkg::PH_LOWER);
   assign in_start = (state_q == lpfm_pkg::ST_HV_START);
   assign in_wait = (state_q == lpfm_pkg::ST_FAULT_WAIT);

   // Blanking window at the start of each dead time
   assign blank_done = (ph_tmr_q >= lpfm_pkg::TMR_W'(lpfm_pkg::BLANK_CYC));

   // Only a polarity change that first shows after blanking counts as a flip
   assign dir_flip = in_dead && blank_done && (s.current_direction_flag != dir_q);

   // Dead-time end decision
   always_comb begin
      if (cap_q) begin
         dead_done = dir_flip || s.slew_done || at_least(ph_tmr_q, CAP_DT);
      end else begin
         dead_done = s.slew_done || at_least(ph_tmr_q, MAX_DT);
      end
   end

   // Reference tracks the comparator every cycle, so an edge inside the
   // blanking window is absorbed and never seen as a flip later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= 1'b0;
      end else begin
         dir_q <= s.current_direction_flag;
      end
   end

   // Capacitive flag: set on wrong polarity at a fall, decided again at the next fall
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_q <= 1'b0;
      end else if (!running) begin
         cap_q <= 1'b0;
      end else if (gate_fall) begin
         if (s.light_load) begin
            cap_q <= 1'b0;
         end else if (phase_q == lpfm_pkg::PH_LOWER) begin
            cap_q <= s.current_direction_flag;
         end else begin
            cap_q <= !s.current_direction_flag;
         end
      end
   end

   // Half-bridge phase sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= lpfm_pkg::PH_DEAD_TO_UPPER;
         ph_tmr_q <= '0;
      end else if (!running) begin
         phase_q <= lpfm_pkg::PH_DEAD_TO_UPPER;
         ph_tmr_q <= '0;
      end else if (gate_fall || (in_dead && dead_done)) begin
         ph_tmr_q <= '0;
         unique case (phase_q)
            lpfm_pkg::PH_UPPER: phase_q <= lpfm_pkg::PH_DEAD_TO_LOWER;
            lpfm_pkg::PH_DEAD_TO_LOWER: phase_q <= lpfm_pkg::PH_LOWER;
            lpfm_pkg::PH_LOWER: phase_q <= lpfm_pkg::PH_DEAD_TO_UPPER;
            lpfm_pkg::PH_DEAD_TO_UPPER: phase_q <= lpfm_pkg::PH_UPPER;
         endcase
      end else begin
         ph_tmr_q <= ph_tmr_q + lpfm_pkg::TMR_W'(1);
      end
   end

   // Start-up cycle count for peak comparator blanking
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_cyc_q <= '0;
      end else if (!running) begin
         start_cyc_q <= '0;
      end else if (cycle_end && start_cyc_q < lpfm_pkg::CNT_W'(lpfm_pkg::PEAK_IGNORE_CYCLES)) begin
         start_cyc_q <= start_cyc_q + lpfm_pkg::CNT_W'(1);
      end
   end

   lpfm_persist #(.W(lpfm_pkg::CNT_W), .LIMIT(lpfm_pkg::PEAK_OC_CYCLES)) u_peak (
      .clk(clk),
      .rst_n(rst_n),
      .clear(!running),
      .step(cycle_end && start_cyc_q >= lpfm_pkg::CNT_W'(lpfm_pkg::PEAK_IGNORE_CYCLES)),
      .level(s.peak_overcurrent_fault),
      .hit(peak_hit)
   );

   lpfm_persist #(.W(lpfm_pkg::CNT_W), .LIMIT(lpfm_pkg::OVP_CYCLES)) u_ovp (
      .clk(clk),
      .rst_n(rst_n),
      .clear(!running),
      .step(cycle_end),
      .level(s.output_overvoltage_fault),
      .hit(ovp_hit)
   );

   // Continuous-assertion timers for average overcurrent
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_q <= '0;
      end else if (!running || !s.fast_average_overcurrent_fault) begin
         fast_q <= '0;
      end else if (!at_least(fast_q, FAST_OC)) begin
         fast_q <= fast_q + lpfm_pkg::TMR_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_q <= '0;
      end else if (!running || !s.slow_average_overcurrent_fault) begin
         slow_q <= '0;
      end else if (!at_least(slow_q, SLOW_OC)) begin
         slow_q <= slow_q + lpfm_pkg::TMR_W'(1);
      end
   end

   assign fast_hit = at_least(fast_q, FAST_OC);
   assign slow_hit = at_least(slow_q, SLOW_OC);

   // Faults that act on the comparator level at once
   assign level_trip = s.input_undervoltage_fault ||
                       (HAS_INPUT_OVP && s.input_overvoltage_fault) ||
                       s.rail_uvlo || s.over_temp;

   // Faults qualified by a count or a timer first
   assign count_trip = peak_hit || ovp_hit || fast_hit || slow_hit;

   assign trip = level_trip || count_trip;

   // Restart is held off while these conditions persist
   assign hold = (HAS_INPUT_OVP && s.input_overvoltage_fault) || s.over_temp;

   // Top-level state machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= lpfm_pkg::ST_HV_START;
         wait_q <= '0;
      end else begin
         unique case (state_q)
            lpfm_pkg::ST_HV_START: begin
               wait_q <= '0;
               if (s.supply_start_level) begin
                  state_q <= lpfm_pkg::ST_RUN;
               end
            end
            lpfm_pkg::ST_RUN: begin
               wait_q <= '0;
               if (trip) begin
                  state_q <= lpfm_pkg::ST_FAULT_WAIT;
               end
            end
            lpfm_pkg::ST_FAULT_WAIT: begin
               // New faults are ignored here; the wait runs to its end
               if (!at_least(wait_q, FAULT_WAIT)) begin
                  wait_q <= wait_q + lpfm_pkg::TMR_W'(1);
               end else if (!hold) begin
                  state_q <= lpfm_pkg::ST_HV_START;
               end
            end
            default: state_q <= lpfm_pkg::ST_HV_START;
         endcase
      end
   end

   // Gate on-signals; they drop one cycle after a trip is seen, with the state change, not one later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upper_gate_on <= 1'b0;
         lower_gate_on <= 1'b0;
      end else begin
         // Bootstrap low blocks only the upper gate and never trips
         upper_gate_on <= running && !trip && phase_q == lpfm_pkg::PH_UPPER &&
                          !s.bootstrap_uvlo;
         lower_gate_on <= running && !trip && phase_q == lpfm_pkg::PH_LOWER;
      end
   end

   // Soft start pull-down; the pin only sinks, so its value stays low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_start_pin_o <= 1'b0;
         soft_start_pin_oe <= 1'b0;
      end else begin
         soft_start_pin_o <= 1'b0;
         soft_start_pin_oe <= running && cap_q;
      end
   end

   // Status; the flag output lags the internal flag by one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         capacitive_region_flag <= 1'b0;
         fault_active <= 1'b0;
      end else begin
         capacitive_region_flag <= cap_q;
         fault_active <= in_wait;
      end
   end

   // Start-up supply controls
   // Source and rail never overlap: both decode the same state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         supply.hv_source_on <= 1'b0;
         supply.hv_source_high <= 1'b0;
         supply.rail_enable <= 1'b0;
      end else begin
         supply.hv_source_on <= in_start && !s.supply_start_level;
         supply.hv_source_high <= in_start && s.supply_short_level;
         supply.rail_enable <= running;
      end
   end

endmodule // lpfm_fault_manager

// ==== lpfm_fault_manager_monitor.sv ====
// Port checker for the protection and fault manager
`timescale 1ns/1ps
module lpfm_fault_manager_chk #(
   parameter int unsigned FAULT_WAIT = 200
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Watched ports
   input wire lpfm_pkg::lpfm_sense_s sense,
   input wire logic upper_gate_on,
   input wire logic lower_gate_on,
   input wire logic soft_start_pin_o,
   input wire logic soft_start_pin_oe,
   input wire lpfm_pkg::lpfm_supply_s supply,
   input wire logic capacitive_region_flag,
   input wire logic fault_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Cycles spent in the current fault wait
   logic [31:0] wait_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wait_q <= 32'h0;
      else wait_q <= fault_active ? wait_q + 32'h1 : 32'h0;
   end
   a_wait_gates_off:
      assert property (fault_active |-> !upper_gate_on && !lower_gate_on)
      else $error("Gate on during fault wait");
   a_wait_full_length:
      assert property ($fell(fault_active) |-> wait_q >= FAULT_WAIT - 2)
      else $error("Fault wait too short");
   a_boot_upper_off:
      assert property (sense.bootstrap_uvlo [*5] |-> !upper_gate_on)
      else $error("Upper gate on with bootstrap low");
   a_rail_both_off:
      assert property (sense.rail_uvlo [*5] |-> !upper_gate_on && !lower_gate_on)
      else $error("Gate on with rail low");
   a_bulk_low_stop:
      assert property (sense.input_undervoltage_fault [*5] |-> !upper_gate_on && !lower_gate_on)
      else $error("Gate on with bulk low");
   a_bulk_high_stop:
      assert property (sense.input_overvoltage_fault [*5] |-> !upper_gate_on && !lower_gate_on)
      else $error("Gate on with bulk high");
   a_cap_pulls_ss:
      assert property ($rose(capacitive_region_flag) |-> ##[0:2] soft_start_pin_oe && !soft_start_pin_o)
      else $error("Soft start not pulled low");
   a_light_no_cap:
      assert property (sense.light_load [*6] |-> !$rose(capacitive_region_flag))
      else $error("Capacitive flag at light load");
   a_rail_source_off:
      assert property (supply.rail_enable |-> !supply.hv_source_on && !$rose(supply.hv_source_on))
      else $error("Source on with rail enabled");
   a_short_high_cur:
      assert property (sense.supply_short_level [*5] ##0 supply.hv_source_on |-> supply.hv_source_high)
      else $error("Start-up current stays low");
   a_gates_need_rail:
      assert property (upper_gate_on || lower_gate_on |-> supply.rail_enable)
      else $error("Gate on without rail");
   c_cap_seen: cover property ($rose(capacitive_region_flag));
   c_fault_in: cover property ($rose(fault_active));
   c_fault_out: cover property ($fell(fault_active));
endmodule // lpfm_fault_manager_chk

bind lpfm_fault_manager lpfm_fault_manager_chk #(.FAULT_WAIT(FAULT_WAIT)) u_chk (
   .clk(clk), .rst_n(rst_n), .sense(sense), .upper_gate_on(upper_gate_on),
   .lower_gate_on(lower_gate_on), .soft_start_pin_o(soft_start_pin_o),
   .soft_start_pin_oe(soft_start_pin_oe), .supply(supply),
   .capacitive_region_flag(capacitive_region_flag), .fault_active(fault_active));

// ==== lpfm_tank_model.sv ====
// Behavioural half-bridge and resonant current model
`timescale 1ns/1ps
module lpfm_tank_model (
   // Clock
   input wire logic clk,
   // Gate on-signals
   input wire logic upper_gate_on,
   input wire logic lower_gate_on,
   // Scenario controls
   input wire logic cap_mode,
   input wire logic slew_en,
   input wire logic [9:0] flip_dly,
   // Comparator levels
   output logic current_direction_flag,
   output logic slew_done
);
   logic [9:0] dead_q = 10'h0;
   initial current_direction_flag = 1'b0;
   initial slew_done = 1'b0;
   always @(posedge clk) begin
      if (upper_gate_on || lower_gate_on) begin
         dead_q <= 10'h0;
         // Capacitive: current reverses before the gate falls
         current_direction_flag <= upper_gate_on ^ cap_mode;
      end else begin
         dead_q <= dead_q + 10'h1;
         // Current turns inductive again flip_dly cycles into the dead time
         if (cap_mode && dead_q == flip_dly) current_direction_flag <= ~current_direction_flag;
      end
      // Node slew ends at a fixed time only when enabled
      slew_done <= slew_en && dead_q == 10'h1E && !(upper_gate_on || lower_gate_on);
   end
endmodule // lpfm_tank_model

// ==== tb_top.sv ====
// Self-checking bench for the protection and fault manager
`timescale 1ns/1ps
module tb_top;
   localparam int FW = 200;
   localparam int MDT = 200;
   localparam int CDT = 300;
   logic clk;
   logic rst_n;
   logic cap_mode;
   logic slew_en;
   logic [9:0] flip_dly;
   logic dir;
   logic slew;
   lpfm_pkg::lpfm_sense_s drv;
   lpfm_pkg::lpfm_sense_s sense;
   logic upper_gate_on;
   logic lower_gate_on;
   logic ss_o;
   logic ss_oe;
   lpfm_pkg::lpfm_supply_s supply;
   logic cap_flag;
   logic fault_active;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int gap;
   // Fast average first, so peak lands at the start of a run
   int fault_bits [8] = '{10, 11, 9, 8, 7, 6, 4, 3};
   always_comb begin
      sense = drv;
      sense.current_direction_flag = dir;
      sense.slew_done = slew;
   end
   always @(posedge clk) cyc <= cyc + 1;
   lpfm_fault_manager #(.FAULT_WAIT(FW), .FAST_OC(40), .SLOW_OC(100), .CAP_DT(CDT),
      .MAX_DT(MDT), .HALF_PERIOD(20), .HAS_INPUT_OVP(1'b1)) dut (.clk(clk), .rst_n(rst_n),
      .sense(sense), .upper_gate_on(upper_gate_on), .lower_gate_on(lower_gate_on),
      .soft_start_pin_o(ss_o), .soft_start_pin_oe(ss_oe), .supply(supply),
      .capacitive_region_flag(cap_flag), .fault_active(fault_active));
   lpfm_tank_model tank (.clk(clk), .upper_gate_on(upper_gate_on),
      .lower_gate_on(lower_gate_on), .cap_mode(cap_mode), .slew_en(slew_en),
      .flip_dly(flip_dly), .current_direction_flag(dir), .slew_done(slew));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic c, input string m);
      check_count++;
      if (c !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic pick(input int k);
      return k == 0 ? fault_active : (k == 1 ? upper_gate_on : lower_gate_on);
   endfunction
   // Bounded wait on a port level, cycles waited in n
   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (pick(k) !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   // Dead time from upper fall to lower rise, second one after a change settles
   task automatic dead_gap(output int g);
      int n;
      repeat (2) begin
         wait_for(1, 1'b1, 2000, n);
         wait_for(1, 1'b0, 2000, n);
         wait_for(2, 1'b1, 2000, g);
      end
   endtask
   task automatic fault_case(input int b);
      int n;
      int t0;
      int o;
      logic hold;
      hold = (b == 6 || b == 3);
      wait_for(2, 1'b1, 4000, n);
      drv[b] = 1'b1;
      wait_for(0, 1'b1, 9000, n);
      t0 = cyc;
      chk(fault_active === 1'b1 && upper_gate_on === 1'b0 && lower_gate_on === 1'b0, "trip");
      if (b == 11) chk(n >= 17 * 40, "peak counted too early");
      if (!hold) drv[b] = 1'b0;
      repeat ($urandom_range(FW - 20, 10)) @(negedge clk);
      o = fault_bits[$urandom_range(7)];
      if (o != b) drv[o] = 1'b1;
      @(negedge clk);
      if (o != b) drv[o] = 1'b0;
      if (hold) begin
         repeat (FW) @(negedge clk);
         chk(fault_active === 1'b1, "restart with level high");
         drv[b] = 1'b0;
      end
      wait_for(0, 1'b0, 2 * FW, n);
      chk(fault_active === 1'b0 && (hold || (cyc - t0 >= FW - 3 && cyc - t0 <= FW + 3)), "wait");
   endtask
   initial begin
      int n;
      void'($urandom(32'h3F99765C));
      drv = '0;
      cap_mode = 1'b0;
      slew_en = 1'b0;
      flip_dly = 10'h064;
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      chk(upper_gate_on === 1'b0 && lower_gate_on === 1'b0 && supply === 3'h0, "reset");
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk(supply.hv_source_on === 1'b1 && supply.hv_source_high === 1'b0, "low source");
      drv.supply_short_level = 1'b1;
      repeat (6) @(negedge clk);
      chk(supply.hv_source_high === 1'b1, "high source");
      drv.supply_start_level = 1'b1;
      repeat (6) @(negedge clk);
      chk(supply.hv_source_on === 1'b0 && supply.rail_enable === 1'b1, "rail on");
      dead_gap(gap);
      chk(gap >= MDT - 2 && gap <= MDT + 8, "max dead time");
      cap_mode = 1'b1;
      dead_gap(gap);
      chk(gap >= 95 && gap <= 112 && cap_flag === 1'b1 && ss_oe === 1'b1, "flip");
      flip_dly = 10'h0FA;
      dead_gap(gap);
      chk(gap > MDT + 20 && gap <= 265 && cap_flag === 1'b1, "long cap dead");
      // Flip inside blanking is ignored, so the long capacitive limit ends the dead time
      flip_dly = 10'h014;
      dead_gap(gap);
      chk(gap >= CDT - 5 && gap <= CDT + 5 && cap_flag === 1'b1, "flip in blanking");
      slew_en = 1'b1;
      dead_gap(gap);
      chk(gap >= 28 && gap <= 42, "slew ends dead time");
      cap_mode = 1'b0;
      dead_gap(gap);
      chk(cap_flag === 1'b0, "flag cleared at fall");
      drv.light_load = 1'b1;
      cap_mode = 1'b1;
      dead_gap(gap);
      chk(cap_flag === 1'b0 && ss_oe === 1'b0, "light load");
      drv.light_load = 1'b0;
      cap_mode = 1'b0;
      dead_gap(gap);
      drv.bootstrap_uvlo = 1'b1;
      repeat (6) @(negedge clk);
      n = 0;
      repeat (400) begin
         @(negedge clk);
         if (upper_gate_on !== 1'b0 || fault_active !== 1'b0) n++;
      end
      wait_for(2, 1'b1, 400, gap);
      chk(n == 0 && lower_gate_on === 1'b1, "bootstrap low");
      drv.bootstrap_uvlo = 1'b0;
      foreach (fault_bits[i]) fault_case(fault_bits[i]);
      test_done();
   end
   initial begin
      #250000;
      n_fail++;
      test_done();
   end
endmodule // tb_top
